// *** rtl/functional_event_alt_request.sv ***
// Routes functional events to reset, fallback-mode or interrupt requests, with an APB register file.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module functional_event_alt_request
  import fear_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic test_mode,
  input wire logic [NUM_SOURCES-1:0] event_in,
  input wire clk_status_t clk_status,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output alt_req_t alt_req,
  output logic fallback_mode_req,
  output logic system_irq_req
);

  typedef struct packed {
    logic [NUM_SOURCES-1:0] ev_s1;
    logic [NUM_SOURCES-1:0] ev_s2;
    logic [NUM_SOURCES-1:0] ev_s3;
    logic [NUM_SOURCES-1:0] ev_level;
    logic [1:0] clk_s1;
    logic [1:0] clk_s2;
    logic [1:0] clk_s3;
    logic [1:0] clk_level;
    logic [SEL_WIDTH-1:0] alt_select;
    logic [SEL_WIDTH-1:0] reset_disable;
    logic [SEL_WIDTH-1:0] event_status;
    logic osc_irq_held;
    alt_req_t req;
    logic fallback_any;
    logic irq_any;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NUM_SOURCES-1:0] ev_captured;
  logic crystal_stalled;
  logic osc_irq_fire;
  logic access_allowed;
  logic bus_write;
  logic [SEL_WIDTH-1:0] wdata16;
  alt_req_t req_now;

  always_comb begin
    // A rise on a pin counts once the second and third stages agree at 1.
    ev_captured = state_reg.ev_s2 & state_reg.ev_s3 & ~state_reg.ev_level;
    // Bit 1 of the clock status is the clock-from-crystal flag, bit 0 the failure flag.
    crystal_stalled = state_reg.clk_level[1] & state_reg.clk_level[0];
    access_allowed = pprot[0] | test_mode;
    bus_write = psel & penable & pwrite & state_reg.ready;
    wdata16 = pwdata[SEL_WIDTH-1:0];
    req_now = '0;
    osc_irq_fire = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (ev_captured[i]) begin
        if (!state_reg.reset_disable[i]) begin
          req_now.reset_seq[i] = 1'b1;
        end else if (state_reg.alt_select[i] == SEL_FALLBACK) begin
          req_now.fallback[i] = 1'b1;
        end else if (i != SRC_OSC_TOO_SLOW || !crystal_stalled) begin
          req_now.interrupt[i] = 1'b1;
        end
      end
    end
    // The oscillator interrupt waits while the system clock hangs on the failed crystal.
    if (state_reg.osc_irq_held && !crystal_stalled) begin
      req_now.interrupt[SRC_OSC_TOO_SLOW] = 1'b1;
      osc_irq_fire = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.ev_s1 = event_in;
    state_next.ev_s2 = state_reg.ev_s1;
    state_next.ev_s3 = state_reg.ev_s2;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (state_reg.ev_s2[i] == state_reg.ev_s3[i]) begin
        state_next.ev_level[i] = state_reg.ev_s3[i];
      end
    end
    state_next.clk_s1 = clk_status;
    state_next.clk_s2 = state_reg.clk_s1;
    state_next.clk_s3 = state_reg.clk_s2;
    for (int i = 0; i < 2; i++) begin
      if (state_reg.clk_s2[i] == state_reg.clk_s3[i]) begin
        state_next.clk_level[i] = state_reg.clk_s3[i];
      end
    end

    // Requests appear in the cycle after the event is captured.
    state_next.req = req_now;
    state_next.fallback_any = |req_now.fallback;
    state_next.irq_any = |req_now.interrupt;

    if (osc_irq_fire) begin
      state_next.osc_irq_held = 1'b0;
    end
    // Only a stalled clock parks the oscillator interrupt; otherwise it leaves with the capture.
    if (ev_captured[SRC_OSC_TOO_SLOW] && state_reg.reset_disable[SRC_OSC_TOO_SLOW] && crystal_stalled &&
        state_reg.alt_select[SRC_OSC_TOO_SLOW] == SEL_INTERRUPT) begin
      state_next.osc_irq_held = 1'b1;
    end

    // Register writes; outside test mode, user-mode writes leave the configuration unchanged.
    if (bus_write && access_allowed) begin
      if (paddr == ADDR_ALT_SELECT) begin
        state_next.alt_select = wdata16;
        state_next.alt_select[SEL_WIDTH-1:NUM_SOURCES] = '0;
      end else if (paddr == ADDR_RESET_DISABLE) begin
        state_next.reset_disable = wdata16;
        state_next.reset_disable[SEL_WIDTH-1:NUM_SOURCES] = '0;
      end else if (paddr == ADDR_EVENT_STATUS) begin
        state_next.event_status = state_reg.event_status & ~wdata16;
      end
    end
    // A new event sets its status bit even when a clear lands in the same cycle.
    state_next.event_status[NUM_SOURCES-1:0] = state_next.event_status[NUM_SOURCES-1:0] | ev_captured;

    // APB: answer in the first access cycle, with read data prepared during setup.
    state_next.ready = 1'b0;
    state_next.slverr = 1'b0;
    if (psel && !penable) begin
      state_next.ready = 1'b1;
      state_next.rdata = '0;
      if (paddr == ADDR_ALT_SELECT) begin
        state_next.rdata[SEL_WIDTH-1:0] = state_reg.alt_select;
      end else if (paddr == ADDR_RESET_DISABLE) begin
        state_next.rdata[SEL_WIDTH-1:0] = state_reg.reset_disable;
      end else if (paddr == ADDR_EVENT_STATUS) begin
        state_next.rdata[SEL_WIDTH-1:0] = state_reg.event_status;
      end else begin
        state_next.slverr = 1'b1;
      end
    end else if (psel && penable && !state_reg.ready) begin
      state_next.ready = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.alt_select <= ALT_SELECT_RESET;
      state_reg.reset_disable <= RESET_DISABLE_RESET;
      state_reg.event_status <= EVENT_STATUS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign prdata = state_reg.rdata;
  assign alt_req = state_reg.req;
  assign fallback_mode_req = state_reg.fallback_any;
  assign system_irq_req = state_reg.irq_any;

endmodule

// *** rtl/fear_pkg.sv ***
// Package with constants, register map and carrier types for the functional alternate request block.
//
// Summary of operation
// - A disabled functional event raises a fallback-mode or interrupt request instead of reset.
// - Supervisor or test mode may read and write the selection register.
// - User mode outside test mode may only read the selection register; its writes are ignored.
// - Disabled external reset: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled flash fatal error: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled 4.5 V low voltage: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled clock out of range: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled oscillator too slow: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled PLL failure: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled checkstop: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled software reset: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled debug core reset: selection 0 gives fallback request, 1 gives interrupt.
// - Disabled scan port reset: selection 0 gives fallback request, 1 gives interrupt.
// - Oscillator-too-slow interrupt is held while system clock runs from the failed crystal.
// - That held interrupt is issued once the crystal oscillator recovers.
// - Disable bit 0 starts a reset sequence; 1 gives the alternate request.
package fear_pkg;

  localparam int NUM_SOURCES = 10;
  localparam int SEL_WIDTH = 16;

  // Source indices, also the bit positions in every register of the block.
  localparam int SRC_EXTERNAL_RESET = 0;
  localparam int SRC_NVM_FATAL = 1;
  localparam int SRC_LOW_VOLTAGE_HIGH_RAIL = 2;
  localparam int SRC_CLOCK_OUT_OF_RANGE = 3;
  localparam int SRC_OSC_TOO_SLOW = 4;
  localparam int SRC_PLL_FAIL = 5;
  localparam int SRC_CHECKSTOP = 6;
  localparam int SRC_SOFTWARE_RESET = 7;
  localparam int SRC_DEBUG_CORE_RESET = 8;
  localparam int SRC_SCAN_PORT_RESET = 9;

  // Byte addresses on the APB.
  localparam logic [7:0] ADDR_ALT_SELECT = 8'h00;
  localparam logic [7:0] ADDR_RESET_DISABLE = 8'h04;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h08;

  localparam logic [SEL_WIDTH-1:0] ALT_SELECT_RESET = 16'h0000;
  localparam logic [SEL_WIDTH-1:0] RESET_DISABLE_RESET = 16'h0000;
  localparam logic [SEL_WIDTH-1:0] EVENT_STATUS_RESET = 16'h0000;

  // Selection bit values.
  localparam logic SEL_FALLBACK = 1'b0;
  localparam logic SEL_INTERRUPT = 1'b1;

  // One set of per-source request pulses toward the outside.
  typedef struct packed {
    logic [NUM_SOURCES-1:0] reset_seq;
    logic [NUM_SOURCES-1:0] fallback;
    logic [NUM_SOURCES-1:0] interrupt;
  } alt_req_t;

  // Clock-source condition seen by the oscillator-too-slow path.
  typedef struct packed {
    logic sysclk_from_crystal;
    logic crystal_failed;
  } clk_status_t;

endpackage

// *** rtl/fear_pkg_dummy_placeholder.sv ***
// Empty file kept out of the build; intentionally holds no design content.

// *** sim/functional_event_alt_request_asserts.sv ***
// Concurrent checks on the ports of the functional event alternate request block.
`timescale 1ns/100ps
module functional_event_alt_request_asserts
  import fear_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic test_mode,
  input wire logic [NUM_SOURCES-1:0] event_in,
  input wire clk_status_t clk_status,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire alt_req_t alt_req,
  input wire logic fallback_mode_req,
  input wire logic system_irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pll_event;
    $rose(event_in[SRC_PLL_FAIL]);
  endsequence
  sequence s_pll_answer;
    alt_req.reset_seq[SRC_PLL_FAIL] || alt_req.fallback[SRC_PLL_FAIL] || alt_req.interrupt[SRC_PLL_FAIL];
  endsequence
  a_event_to_request: assert property (s_pll_event |-> ##4 s_pll_answer) else $error("late request");
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error reply");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
  a_fallback_summary: assert property (fallback_mode_req == (|alt_req.fallback)) else $error("fallback summary");
  a_irq_summary: assert property (system_irq_req == (|alt_req.interrupt)) else $error("irq summary");
  a_one_destination: assert property ((alt_req.fallback & alt_req.interrupt) == '0 &&
    (alt_req.reset_seq & (alt_req.fallback | alt_req.interrupt)) == '0) else $error("two destinations");
  a_no_osc_irq_held: assert property ((clk_status == 2'b11) [*6] |-> !alt_req.interrupt[SRC_OSC_TOO_SLOW])
    else $error("osc irq while clock failed");
endmodule
bind functional_event_alt_request functional_event_alt_request_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
  .test_mode(test_mode), .event_in(event_in), .clk_status(clk_status), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .alt_req(alt_req), .fallback_mode_req(fallback_mode_req), .system_irq_req(system_irq_req));

// *** sim/alt_req_sink.sv ***
// Model of the mode entry and interrupt controllers that take the alternate requests.
`timescale 1ns/100ps
module alt_req_sink
  import fear_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire alt_req_t alt_req,
  input wire logic fallback_mode_req,
  input wire logic system_irq_req
);
  int n_fb;
  int n_irq;
  alt_req_t last;
  // Each pulse is one request; the last non-empty request set is kept for inspection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_fb <= 0;
      n_irq <= 0;
      last <= '0;
    end else begin
      if (fallback_mode_req) n_fb <= n_fb + 1;
      if (system_irq_req) n_irq <= n_irq + 1;
      if (alt_req != '0) last <= alt_req;
    end
  end
endmodule

// *** sim/functional_event_alt_request_tb.sv ***
// Self-checking testbench for the functional event alternate request block.
`timescale 1ns/100ps
module functional_event_alt_request_tb;
  import fear_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, test_mode, pready, pslverr, fb_req, irq_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pprot;
  logic [NUM_SOURCES-1:0] event_in;
  clk_status_t clk_status;
  alt_req_t alt_req, e;
  logic [31:0] sel;
  int n_errors, checks, cyc, n0;
  functional_event_alt_request dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .test_mode(test_mode), .event_in(event_in),
    .clk_status(clk_status), .pready(pready), .pslverr(pslverr), .prdata(prdata), .alt_req(alt_req),
    .fallback_mode_req(fb_req), .system_irq_req(irq_req));
  alt_req_sink sink (.pclk(pclk), .presetn(presetn), .alt_req(alt_req), .fallback_mode_req(fb_req),
    .system_irq_req(irq_req));
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [2:0] p, output logic [31:0] r,
    output logic er);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    // The answer is taken at the rising edge that samples pready high; only the bench timeout ends a hang.
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    logic [31:0] r;
    logic er;
    apb(a, 1'b1, d, p, r, er);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic er;
    apb(a, 1'b0, 32'h0000_0000, 3'b001, r, er);
    chk(r, x);
    chk({31'h0000_0000, er}, {31'h0000_0000, xe});
  endtask
  task ev(input int i);
    event_in[i] <= 1'b1;
    repeat (6) @(posedge pclk);
    event_in[i] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      wrap_up;
    end
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pprot = 0;
    test_mode = 0; event_in = 0; clk_status = 2'b00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_ALT_SELECT, 32'h0000_0000, 1'b0);
    rd(8'h0C, 32'h0000_0000, 1'b1);
    wr(ADDR_ALT_SELECT, 32'hFFFF_FFFF, 3'b000);
    rd(ADDR_ALT_SELECT, 32'h0000_0000, 1'b0);
    test_mode <= 1'b1;
    wr(ADDR_ALT_SELECT, 32'h0000_FFFF, 3'b000);
    test_mode <= 1'b0;
    rd(ADDR_ALT_SELECT, 32'h0000_03FF, 1'b0);
    $display("register access test done");
    wr(ADDR_RESET_DISABLE, 32'h0000_03FE, 3'b001);
    for (int pass = 0; pass < 2; pass++) begin
      sel = pass ? 32'h0000_0155 : 32'h0000_02AA;
      wr(ADDR_ALT_SELECT, sel, 3'b001);
      for (int i = 0; i < NUM_SOURCES; i++) begin
        ev(i);
        e = '0;
        if (i == 0) e.reset_seq[i] = 1'b1;
        else if (sel[i]) e.interrupt[i] = 1'b1;
        else e.fallback[i] = 1'b1;
        chk(32'(sink.last), 32'(e));
      end
    end
    chk(sink.n_fb, 9);
    chk(sink.n_irq, 9);
    $display("event routing test done");
    n0 = sink.n_irq;
    clk_status <= 2'b11;
    repeat (4) @(posedge pclk);
    ev(SRC_OSC_TOO_SLOW);
    chk(sink.n_irq, n0);
    clk_status <= 2'b00;
    repeat (8) @(posedge pclk);
    chk(sink.n_irq, n0 + 1);
    clk_status <= 2'b01;
    repeat (4) @(posedge pclk);
    ev(SRC_OSC_TOO_SLOW);
    chk(sink.n_irq, n0 + 2);
    $display("oscillator hold test done");
    rd(ADDR_RESET_DISABLE, 32'h0000_03FE, 1'b0);
    rd(ADDR_EVENT_STATUS, 32'h0000_03FF, 1'b0);
    wr(ADDR_EVENT_STATUS, 32'h0000_03FF, 3'b001);
    rd(ADDR_EVENT_STATUS, 32'h0000_0000, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_ALT_SELECT, 32'h0000_0000, 1'b0);
    $display("status and reset test done");
    wrap_up;
  end
endmodule
